// *** hdl/tcr_regs_map.vh ***
`ifndef TCR_REGS_MAP_VH
`define TCR_REGS_MAP_VH
// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define TCR_ADDR_LAUNCH     6'h00
`define TCR_ADDR_CFG_TWO    6'h01
`define TCR_ADDR_FLAGS      6'h02
`define TCR_ADDR_ENABLE     6'h03
`define TCR_ADDR_COARSE_HI  6'h04
`define TCR_ADDR_COARSE_LO  6'h05
`define TCR_ADDR_REFCLK_HI  6'h06
`define TCR_ADDR_REFCLK_LO  6'h07
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TCR_RST_CFG_TWO     8'h40
`define TCR_RST_FLAGS       5'h00
`define TCR_RST_ENABLE      3'h7
`define TCR_RST_LIMIT       8'hFF
`define TCR_RST_BYTE        8'h00
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TCR_CAL_MSB         7
`define TCR_CAL_LSB         6
`define TCR_AVG_MSB         5
`define TCR_AVG_LSB         3
`define TCR_STOP_MSB        2
`define TCR_STOP_LSB        0
`define TCR_FLG_DONE        4
`define TCR_FLG_BEGUN       3
`define TCR_FLG_REFOVF      2
`define TCR_FLG_COARSEOVF   1
`define TCR_FLG_RESULT      0
`define TCR_CMD_AUTOINC     7
`define TCR_CMD_WRITE       6
// ------------------------------------------------------------
// spans and counts
// ------------------------------------------------------------
`define TCR_CAL_SPAN0       8'h02
`define TCR_CAL_SPAN1       8'h0A
`define TCR_CAL_SPAN2       8'h14
`define TCR_CAL_SPAN3       8'h28
`define TCR_STOP_MAX_CODE   3'h4
`define TCR_BITS_PER_BYTE   3'h7
`endif

// *** hdl/tcr_config_irq_regs.v ***
`timescale 1ns/1ps
// Behaviour
// [R1] calibration span field picks 2/10/20/40 clock periods, reset code 01
// [R2] averaging field picks 1..128 measurement cycles, reset code 000
// [R3] stop-count field expects 1..5 stops, codes above 100 mean one
// [R4] status bit 4 set on completion, cleared by writing one
// [R5] status bit 3 set when start received, cleared by writing one
// [R6] reference counter overflow sets bit 2 and aborts measurement
// [R7] coarse counter overflow sets bit 1 and aborts measurement
// [R8] status bit 0 set on completion, cleared by writing one or by a launch write
// [R9] status upper three bits reserved zero, register resets to 00h
// [R10] mask bits 2..0 enable interrupts, reset to 07h
// [R11] masked flag still sets and reads, but does not drive pin
// [R12] coarse threshold is 16 bits from 04h/05h, both reset FFh
// [R13] software never writes one into the coarse threshold low byte
// [R14] reference threshold high byte at 06h, read/write, resets FFh
// [R15] second config at 01h resets 40h, access only while selected
// [R16] launch write clears status, clears results, begins measurement
// [R17] reference threshold low byte at 07h, read/write, resets FFh
// [R18] interrupt pin low while any enabled flag is set
// [R19] overflow raised when counter reaches programmed 16-bit threshold
`include "tcr_regs_map.vh"

module tcr_config_irq_regs
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire       serialClk,
  input  wire       channelSelectN,
  input  wire       serialDataIn,
  input  wire       startPin,
  input  wire       stopPin,
  output reg        serialDataOut,
  output reg        serialDataOe,
  output reg        irqOutN,
  output reg        measBusy,
  output reg        resultClear
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ARM  = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;
  localparam [1:0] ST_CAL  = 2'h3;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // all five pins come from outside; stage one is read only by stage two
  reg  [4:0] syncA_q;
  reg  [4:0] syncB_q;
  reg  [4:0] syncC_q;
  wire [4:0] pinsRaw;

  assign pinsRaw = {stopPin, startPin, serialDataIn, channelSelectN, serialClk};

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_q <= 5'h02;
      syncB_q <= 5'h02;
      syncC_q <= 5'h02;
    end
    else
    begin
      syncA_q <= pinsRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  wire sclkRise  = syncB_q[0] & ~syncC_q[0];
  wire sclkFall  = ~syncB_q[0] & syncC_q[0];
  wire selected  = ~syncB_q[1];
  wire mosiBit   = syncB_q[2];
  wire startEdge = syncB_q[3] & ~syncC_q[3];
  wire stopEdge  = syncB_q[4] & ~syncC_q[4];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [7:0]  cfgTwo_q;
  reg  [4:0]  flags_q;
  reg  [2:0]  enable_q;
  reg  [7:0]  coarseHi_q;
  reg  [7:0]  coarseLo_q;
  reg  [7:0]  refHi_q;
  reg  [7:0]  refLo_q;
  reg         launchBit_q;

  wire [1:0]  second_cal_span_select = cfgTwo_q[`TCR_CAL_MSB:`TCR_CAL_LSB];
  wire [2:0]  averaging_count_select = cfgTwo_q[`TCR_AVG_MSB:`TCR_AVG_LSB];
  wire [2:0]  stopCountSelect        = cfgTwo_q[`TCR_STOP_MSB:`TCR_STOP_LSB];
  wire [15:0] coarseLimit            = {coarseHi_q, coarseLo_q}; // [R12]
  wire [15:0] refclkLimit            = {refHi_q, refLo_q}; // [R14] [R17]

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function [7:0] calSpan;
    input [1:0] code;
    begin
      case (code)
        2'h0:    calSpan = `TCR_CAL_SPAN0;
        2'h1:    calSpan = `TCR_CAL_SPAN1;
        2'h2:    calSpan = `TCR_CAL_SPAN2;
        default: calSpan = `TCR_CAL_SPAN3;
      endcase
    end
  endfunction

  function [7:0] readReg;
    input [5:0] addr;
    begin
      case (addr)
        `TCR_ADDR_LAUNCH:    readReg = {7'h00, launchBit_q};
        `TCR_ADDR_CFG_TWO:   readReg = cfgTwo_q;
        `TCR_ADDR_FLAGS:     readReg = {3'h0, flags_q}; // [R9]
        `TCR_ADDR_ENABLE:    readReg = {5'h00, enable_q};
        `TCR_ADDR_COARSE_HI: readReg = coarseHi_q;
        `TCR_ADDR_COARSE_LO: readReg = coarseLo_q;
        `TCR_ADDR_REFCLK_HI: readReg = refHi_q;
        `TCR_ADDR_REFCLK_LO: readReg = refLo_q;
        default:             readReg = 8'h00;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // serial slave: command byte then data bytes, msb first
  // ------------------------------------------------------------
  reg  [2:0] bitCnt_q;
  reg  [7:0] rxShift_q;
  reg  [7:0] txShift_q;
  reg        haveCmd_q;
  reg        cmdWrite_q;
  reg        cmdAutoInc_q;
  reg  [5:0] addr_q;

  wire [7:0] rxByte   = {rxShift_q[6:0], mosiBit};
  wire       byteDone = selected & sclkRise & (bitCnt_q == `TCR_BITS_PER_BYTE);
  wire       wrStrobe = byteDone & haveCmd_q & cmdWrite_q;
  wire [5:0] nextAddr = cmdAutoInc_q ? addr_q + 6'h01 : addr_q;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bitCnt_q      <= 3'h0;
      rxShift_q     <= 8'h00;
      txShift_q     <= 8'h00;
      haveCmd_q     <= 1'b0;
      cmdWrite_q    <= 1'b0;
      cmdAutoInc_q  <= 1'b0;
      addr_q        <= 6'h00;
      serialDataOut <= 1'b0;
      serialDataOe  <= 1'b0;
    end
    else if (!selected)
    begin
      // deselect ends the frame; a partial byte is dropped
      bitCnt_q     <= 3'h0;
      haveCmd_q    <= 1'b0;
      serialDataOe <= 1'b0; // [R15]
    end
    else
    begin
      serialDataOe <= 1'b1;
      if (sclkRise)
      begin
        bitCnt_q  <= bitCnt_q + 3'h1;
        rxShift_q <= rxByte;
      end
      if (byteDone)
      begin
        if (!haveCmd_q)
        begin
          haveCmd_q    <= 1'b1;
          cmdWrite_q   <= rxByte[`TCR_CMD_WRITE];
          cmdAutoInc_q <= rxByte[`TCR_CMD_AUTOINC];
          addr_q       <= rxByte[5:0];
          txShift_q    <= readReg(rxByte[5:0]);
        end
        else
        begin
          addr_q    <= nextAddr;
          txShift_q <= readReg(nextAddr);
        end
      end
      else if (sclkFall)
      begin
        serialDataOut <= txShift_q[7];
        txShift_q     <= {txShift_q[6:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // measurement sequencer
  // ------------------------------------------------------------
  reg  [1:0]  state_q;
  reg  [15:0] refCnt_q;
  reg  [15:0] coarseCnt_q;
  reg  [2:0]  stopsSeen_q;
  reg  [7:0]  cyclesLeft_q;
  reg  [7:0]  calCnt_q;

  wire        launchWr   = wrStrobe & (addr_q == `TCR_ADDR_LAUNCH) & rxByte[0];
  wire [2:0]  stopsNeed  = (stopCountSelect > `TCR_STOP_MAX_CODE) ?
                           3'h0 : stopCountSelect; // [R3]
  wire [7:0]  avgCycles  = 8'h01 << averaging_count_select; // [R2]
  wire        running    = (state_q == ST_RUN);
  wire        refOvf     = running & (refCnt_q == refclkLimit); // [R19]
  wire        coarseOvf  = running & (coarseCnt_q == coarseLimit); // [R19]
  wire        lastStop   = running & stopEdge & (stopsSeen_q == stopsNeed);
  wire        calEnd     = (state_q == ST_CAL) &
                           (calCnt_q == calSpan(second_cal_span_select)); // [R1]
  wire        beginEvt   = (state_q == ST_ARM) & startEdge & ~launchWr;
  wire        doneEvt    = calEnd & ~launchWr;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q      <= ST_IDLE;
      refCnt_q     <= 16'h0000;
      coarseCnt_q  <= 16'h0000;
      stopsSeen_q  <= 3'h0;
      cyclesLeft_q <= 8'h00;
      calCnt_q     <= 8'h00;
    end
    else if (launchWr)
    begin
      state_q      <= ST_ARM; // [R16]
      cyclesLeft_q <= avgCycles - 8'h01;
      stopsSeen_q  <= 3'h0;
      refCnt_q     <= 16'h0000;
      coarseCnt_q  <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_ARM:
        begin
          if (startEdge)
          begin
            state_q     <= ST_RUN;
            refCnt_q    <= 16'h0000;
            coarseCnt_q <= 16'h0000;
            stopsSeen_q <= 3'h0;
          end
        end
        ST_RUN:
        begin
          refCnt_q    <= refCnt_q + 16'h0001;
          coarseCnt_q <= stopEdge ? 16'h0000 : coarseCnt_q + 16'h0001;
          if (refOvf | coarseOvf)
            state_q <= ST_IDLE; // [R6] [R7]
          else if (lastStop)
          begin
            if (cyclesLeft_q == 8'h00)
            begin
              state_q  <= ST_CAL;
              calCnt_q <= 8'h00;
            end
            else
            begin
              // averaging: wait for the next start of the sequence
              state_q      <= ST_ARM;
              cyclesLeft_q <= cyclesLeft_q - 8'h01;
            end
          end
          else if (stopEdge)
            stopsSeen_q <= stopsSeen_q + 3'h1;
        end
        ST_CAL:
        begin
          calCnt_q <= calCnt_q + 8'h01;
          if (calEnd)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register writes and status flags
  // ------------------------------------------------------------
  reg  [4:0] flagsSet;
  reg  [4:0] flagsClr;
  wire [4:0] flags_d = (flags_q & ~flagsClr) | flagsSet;

  always @*
  begin
    flagsSet = 5'h00;
    flagsClr = 5'h00;
    flagsSet[`TCR_FLG_DONE]      = doneEvt; // [R4]
    flagsSet[`TCR_FLG_RESULT]    = doneEvt; // [R8]
    flagsSet[`TCR_FLG_BEGUN]     = beginEvt; // [R5]
    flagsSet[`TCR_FLG_REFOVF]    = refOvf & ~launchWr; // [R6]
    flagsSet[`TCR_FLG_COARSEOVF] = coarseOvf & ~launchWr; // [R7]
    if (launchWr)
      flagsClr = 5'h1F; // [R16]
    else if (wrStrobe & (addr_q == `TCR_ADDR_FLAGS))
      flagsClr = rxByte[4:0]; // [R4] [R5] [R6] [R7] [R8]
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgTwo_q    <= `TCR_RST_CFG_TWO; // [R1] [R2] [R15]
      flags_q     <= `TCR_RST_FLAGS; // [R9]
      enable_q    <= `TCR_RST_ENABLE; // [R10]
      coarseHi_q  <= `TCR_RST_LIMIT; // [R12]
      coarseLo_q  <= `TCR_RST_LIMIT; // [R12]
      refHi_q     <= `TCR_RST_LIMIT; // [R14]
      refLo_q     <= `TCR_RST_LIMIT; // [R17]
      launchBit_q <= 1'b0;
      irqOutN     <= 1'b1;
      measBusy    <= 1'b0;
      resultClear <= 1'b0;
    end
    else
    begin
      // set beats a same-cycle write-one clear; a launch write masks every set and clears all five flags
      flags_q     <= flags_d;
      // pin changes on the same edge as the flags, straight from a flop
      irqOutN     <= ~|(flags_d[2:0] & enable_q); // [R11] [R18]
      measBusy    <= (state_q != ST_IDLE);
      resultClear <= launchWr; // [R16]
      if (launchWr)
        launchBit_q <= 1'b1;
      else if (doneEvt | refOvf | coarseOvf)
        launchBit_q <= 1'b0;
      if (wrStrobe)
      begin
        case (addr_q)
          `TCR_ADDR_CFG_TWO:   cfgTwo_q   <= rxByte; // [R15]
          `TCR_ADDR_ENABLE:    enable_q   <= rxByte[2:0]; // [R10]
          `TCR_ADDR_COARSE_HI: coarseHi_q <= rxByte;
          // a low byte of one would overflow at once; software avoids it
          `TCR_ADDR_COARSE_LO: coarseLo_q <= rxByte; // [R13]
          `TCR_ADDR_REFCLK_HI: refHi_q    <= rxByte; // [R14]
          `TCR_ADDR_REFCLK_LO: refLo_q    <= rxByte; // [R17]
          default:             cfgTwo_q   <= cfgTwo_q;
        endcase
      end
    end
  end

endmodule

// *** dv/tcr_spi_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// serial host, clock stands still low between frames
// ----------------------------------------------------------------
module tcr_spi_host
(
  output logic serialClk,
  output logic channelSelectN,
  output logic serialDataIn,
  input  wire  serialDataOut
);
  logic [7:0] wr [0:7];
  logic [7:0] rd [0:7];
  initial
  begin
    serialClk = 1'b0;
    channelSelectN = 1'b1;
    serialDataIn = 1'b0;
  end
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--)
    begin
      serialDataIn = tx[b];
      #32 serialClk = 1'b1;
      rx[b] = serialDataOut;
      #32 serialClk = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input int n);
    logic [7:0] junk;
    channelSelectN = 1'b0;
    #32 shift(cmd, junk);
    for (int i = 0; i < n; i++)
      shift(wr[i], rd[i]);
    #32 channelSelectN = 1'b1;
    // released line must not keep showing the last bit
    serialDataIn = ~serialDataIn;
    #96;
  endtask
endmodule

// *** dv/tcr_regs_chk.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checks
// ----------------------------------------------------------------
module tcr_regs_chk
(
  input wire clock,
  input wire rst_n,
  input wire serialClk,
  input wire channelSelectN,
  input wire serialDataOut,
  input wire serialDataOe,
  input wire irqOutN,
  input wire measBusy,
  input wire resultClear
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence launchSeen;
    resultClear ##1 measBusy;
  endsequence
  rstIdle_a: assert property ($rose(rst_n) |-> irqOutN && !measBusy)
    else $error("outputs not idle after reset");
  pulseOne_a: assert property (resultClear |=> !resultClear)
    else $error("clear pulse too long");
  launchBusy_a: assert property (resultClear |=> measBusy)
    else $error("launch did not start sequencer");
  busyCause_a: assert property ($rose(measBusy) |-> $past(resultClear))
    else $error("sequencer started without launch");
  clearIrq_a: assert property (launchSeen |-> irqOutN)
    else $error("launch left interrupt pending");
  quietStart_a: assert property ($rose(measBusy) |-> irqOutN[*2])
    else $error("interrupt during fresh measurement");
  oeOff_a: assert property (channelSelectN[*6] |-> !serialDataOe)
    else $error("data out driven while deselected");
  oeOn_a: assert property (!channelSelectN[*6] |-> serialDataOe)
    else $error("data out not driven while selected");
  misoEdge_a: assert property ($changed(serialDataOut) |-> !serialClk)
    else $error("data out moved while serial clock high");
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clock;
  logic rst_n;
  logic startPin;
  logic stopPin;
  wire  serialClk, channelSelectN, serialDataIn, serialDataOut;
  wire  serialDataOe, irqOutN, measBusy, resultClear;
  // pulled-up data line when the device lets go
  wire  misoLine = serialDataOe ? serialDataOut : 1'b1;
  int   errTotal = 0;
  int   comparisons = 0;
  int   cycles = 0;
  int   lat [0:3];
  tcr_config_irq_regs dut (.clock, .rst_n, .serialClk, .channelSelectN, .serialDataIn,
    .startPin, .stopPin, .serialDataOut, .serialDataOe, .irqOutN, .measBusy, .resultClear);
  tcr_spi_host host (.serialClk, .channelSelectN, .serialDataIn, .serialDataOut(misoLine));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      errTotal++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [5:0] a, input logic [7:0] v);
    host.wr[0] = v;
    host.frame({2'b01, a}, 1);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    host.frame({2'b00, a}, 1);
    check("register", host.rd[0], exp);
  endtask
  task automatic pulse(input logic stop);
    @(posedge clock);
    #1 startPin = !stop;
    stopPin = stop;
    repeat (4) @(posedge clock);
    #1 startPin = 1'b0;
    stopPin = 1'b0;
    repeat (4) @(posedge clock);
    // step off the edge so outputs read afterwards are settled
    #1;
  endtask
  task automatic launch(input logic [7:0] cfg);
    wreg(6'h01, cfg);
    wreg(6'h00, 8'h01);
  endtask
  task automatic idle(output int n);
    n = 0;
    while (measBusy !== 1'b0 && n < 500)
    begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    logic [7:0] rv [0:6] = '{8'h40, 8'h00, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    host.frame(8'h81, 7);
    for (int i = 0; i < 7; i++)
      check("reset", host.rd[i], rv[i]);
    wreg(6'h3F, 8'h5A);
    rchk(6'h3F, 8'h00);
    // low limit byte gets 23h, never one
    for (int i = 0; i < 4; i++)
      host.wr[i] = 8'h12 + 8'(i * 17);
    host.frame(8'hC4, 4);
    host.frame(8'h84, 4);
    for (int i = 0; i < 4; i++)
      check("limit", host.rd[i], 8'h12 + 8'(i * 17));
    for (int i = 0; i < 4; i++)
      host.wr[i] = 8'hFF;
    host.frame(8'hC4, 4);
    $display("test_regs done");
  endtask
  task automatic test_stops();
    logic [2:0] code [0:3] = '{3'h0, 3'h4, 3'h5, 3'h7};
    int n;
    for (int i = 0; i < 4; i++)
    begin
      n = (code[i] > 3'h4) ? 1 : code[i] + 1;
      launch({5'h00, code[i]});
      pulse(1'b0);
      repeat (n - 1) pulse(1'b1);
      check("busy", {7'h00, measBusy}, 8'h01);
      pulse(1'b1);
      idle(n);
      check("irq", {7'h00, irqOutN}, 8'h00);
      rchk(6'h02, 8'h19);
    end
    wreg(6'h02, 8'hE0);
    rchk(6'h02, 8'h19);
    wreg(6'h02, 8'h11);
    rchk(6'h02, 8'h08);
    check("irq", {7'h00, irqOutN}, 8'h01);
    rchk(6'h00, 8'h00);
    $display("test_stops done");
  endtask
  task automatic test_avg_cal();
    logic [7:0] span [1:3] = '{8'h00, 8'h0A, 8'h1E};
    launch(8'h08);
    pulse(1'b0);
    pulse(1'b1);
    check("busy", {7'h00, measBusy}, 8'h01);
    pulse(1'b0);
    pulse(1'b1);
    idle(lat[0]);
    rchk(6'h02, 8'h19);
    // span code 00 ends inside the stop pulse, so timing starts at 01
    for (int i = 1; i < 4; i++)
    begin
      launch({i[1:0], 6'h00});
      pulse(1'b0);
      pulse(1'b1);
      idle(lat[i]);
      check("span", 8'(lat[i] - lat[1]), span[i]);
    end
    $display("test_avg_cal done");
  endtask
  task automatic test_mask();
    int n;
    wreg(6'h03, 8'h00);
    launch(8'h00);
    pulse(1'b0);
    pulse(1'b1);
    idle(n);
    check("irq", {7'h00, irqOutN}, 8'h01);
    rchk(6'h02, 8'h19);
    wreg(6'h03, 8'h01);
    check("irq", {7'h00, irqOutN}, 8'h00);
    rchk(6'h03, 8'h01);
    wreg(6'h03, 8'h07);
    $display("test_mask done");
  endtask
  task automatic test_ovf();
    int n;
    wreg(6'h06, 8'h00);
    wreg(6'h07, 8'h40);
    launch(8'h00);
    pulse(1'b0);
    idle(n);
    rchk(6'h02, 8'h0C);
    check("irq", {7'h00, irqOutN}, 8'h00);
    rchk(6'h00, 8'h00);
    wreg(6'h06, 8'hFF);
    wreg(6'h07, 8'hFF);
    wreg(6'h04, 8'h00);
    wreg(6'h05, 8'h30);
    launch(8'h00);
    pulse(1'b0);
    idle(n);
    rchk(6'h02, 8'h0A);
    wreg(6'h02, 8'h0E);
    rchk(6'h02, 8'h00);
    check("irq", {7'h00, irqOutN}, 8'h01);
    $display("test_ovf done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    startPin = 1'b0;
    stopPin = 1'b0;
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    test_regs();
    test_stops();
    test_avg_cal();
    test_mask();
    test_ovf();
    wrap_up();
  end
endmodule
bind tcr_config_irq_regs tcr_regs_chk chk (.clock, .rst_n, .serialClk, .channelSelectN,
  .serialDataOut, .serialDataOe, .irqOutN, .measBusy, .resultClear);
